// File: pkg/rtu_pkg.sv
// Constants, types and register map for the reset and trap unit.
// Assumes a 32-bit classic Wishbone slave on a single 50 MHz clock.
package rtu_pkg;

  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] STACK_LIMIT_RST = 16'hFFFE;
  localparam logic [3:0] PRIO_ALL_OFF = 4'h7;
  localparam logic [3:0] PRIO_MATH = 4'hB;
  localparam logic [3:0] PRIO_ADDR = 4'hC;
  localparam logic [3:0] PRIO_STACK = 4'hD;
  localparam logic [3:0] PRIO_OSC = 4'hE;
  localparam logic [3:0] PRIO_HARD_MIN = 4'hC;
  localparam int PRIO_TOP_BIT = 3;
  localparam logic [4:0] MAX_SHIFT = 5'h10;

  // Word byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_STACK_LIMIT = 8'h08;
  localparam logic [7:0] ADR_RESET_CTRL = 8'h0C;
  localparam logic [7:0] ADR_PRIO = 8'h10;

  // Control fields
  localparam int CTRL_OVA_EN = 0;
  localparam int CTRL_OVB_EN = 1;
  localparam int CTRL_COV_EN = 2;
  localparam int CTRL_ACK = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Status / reset control field positions
  localparam int ST_MATH = 0;
  localparam int ST_ADDR = 1;
  localparam int ST_STACK = 2;
  localparam int ST_OSC = 3;
  localparam int RC_TRAP_CONFLICT = 15;
  localparam int RC_ILLEGAL = 14;
  localparam int RC_WATCHDOG = 4;
  localparam int RC_UNINIT_W = 9;
  localparam int RC_BROWNOUT = 1;
  localparam int RC_POWERON = 0;
  localparam int RC_EXTERNAL = 7;
  localparam int RC_LOCKOUT = 8;
  localparam logic [15:0] RESET_CTRL_RST = 16'h0001;

  typedef enum logic [1:0] {RTU_RUN, RTU_RESET, RTU_FETCH_JUMP, RTU_TRAP} rtu_state_type;

  // Per-instruction event report from the pipeline
  typedef struct packed {
    logic valid;
    logic flushed;
    logic illegal_op;
    logic uninit_w_ptr;
    logic div_zero;
    logic ovf_a31;
    logic ovf_b31;
    logic guard_used;
    logic ovf_a39;
    logic ovf_b39;
    logic sat_off;
    logic is_shift;
    logic [4:0] shift_amt;
  } rtu_exec_type;

  // Data, fetch and stack address events
  typedef struct packed {
    logic data_acc;
    logic word_acc;
    logic [15:0] data_addr;
    logic dual_space;
    logic y_access;
    logic data_unimpl;
    logic x_in_range;
    logic y_in_range;
    logic prog_data_unimpl;
    logic fetch_vector;
    logic pc_load;
    logic pc_unimpl;
    logic sp_load;
    logic [15:0] sp_value;
    logic vector_invalid;
  } rtu_addr_type;

  typedef struct packed {
    rtu_state_type state;
    logic [3:0] ctrl;
    logic [3:0] trap_pend;
    logic [3:0] cur_trap_prio;
    logic hard_active;
    logic [15:0] stack_limit;
    logic [15:0] reset_ctrl;
    logic [3:0] cpu_priority_level;
    logic core_reset;
    logic [23:0] pc;
    logic pc_load;
    logic trap_req;
    logic [3:0] trap_prio;
    logic [31:0] dat;
    logic ack;
    logic err;
  } rtu_state_reg_type;

endpackage

// File: verilog/rtu_reset_trap.sv
// Reset sequencing and trap detection beside the core pipeline.
// Assumes pipeline event inputs are on clk_i; reset pins are asynchronous.
//
// What this block does
// - Any reset clears state, PC to zero
// - Execute jump word, continue at target
// - Eight reset sources vector to reset
// - Watchdog timeout resets the device
// - Uninitialised pointer register use resets
// - Unused opcode execution resets
// - Flushed illegal opcode raises nothing
// - Brown-out detection resets the device
// - Simultaneous traps cause lockout reset
// - Traps non-maskable, levels 8-15, top bit
// - Level 7 masks interrupts, traps still
// - Invalid trap vector raises address error
// - Offending instruction completes before trap, except divide by zero
// - Divide by zero aborts, math trap
// - Enabled bit-31 overflow, no guard: math trap
// - Enabled bit-39 overflow, no saturation: math
// - Oversize shift amount takes math trap
// - Misaligned, unimplemented, vector fetch: address trap
// - Dual-space: other space is unimplemented
// - Jump or PC load to unimplemented: address
// - Stack pointer above limit: stack error
// - Stack pointer below floor: stack error
// - Math 11, address 12, stack 13, osc 14
// - Hard trap conflict resets, sets flag 15
//
// The Wishbone register port and the register offsets are this design's own decisions.
module rtu_reset_trap #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_i,
  input wire logic poweron_reset_i,
  input wire logic brownout_reset_i,
  input wire logic watchdog_timeout_i,
  input wire logic osc_fail_i,
  input wire rtu_pkg::rtu_exec_type exec_i,
  input wire rtu_pkg::rtu_addr_type addr_i,
  input wire logic [23:0] jump_target_i,
  input wire logic jump_valid_i,
  input wire logic trap_return_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic core_reset_o,
  output logic [23:0] pc_o,
  output logic pc_load_o,
  output logic trap_req_o,
  output logic [3:0] trap_prio_o,
  output logic [3:0] cpu_priority_level_o,
  output logic irq_enable_o,
  output logic abort_op_o
);

  // Offsets reach 0x10, so five address bits at least
  if (ADDR_W < 5 || ADDR_W > 32)
  begin : g_addr_w_check
    $error("rtu_reset_trap: ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Async pins; only the second flop is read

  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_r <= 5'h00;
      pin_sync_r <= 5'h00;
    end
    else
    begin
      pin_meta_r <= {osc_fail_i, watchdog_timeout_i, brownout_reset_i, poweron_reset_i, ext_reset_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic ext_s, por_s, bor_s, wdt_s, osc_s;
  assign ext_s = pin_sync_r[0];
  assign por_s = pin_sync_r[1];
  assign bor_s = pin_sync_r[2];
  assign wdt_s = pin_sync_r[3];
  assign osc_s = pin_sync_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // Event detection
  // Pipeline events share clk_i, so no sync

  rtu_pkg::rtu_state_reg_type s_r;
  rtu_pkg::rtu_state_reg_type s_nxt;

  logic ex_ok;
  logic illegal_ev, uninit_ev, math_ev, addr_ev, stack_ev, osc_ev;
  logic misaligned, unimpl_data;
  logic [3:0] new_traps;
  logic multi_trap;
  logic [3:0] top_prio;
  logic hard_conflict;

  always_comb
  begin
    // Flushed instructions raise nothing
    // suppress flushed opcode
    ex_ok = exec_i.valid && !exec_i.flushed;
    illegal_ev = ex_ok && exec_i.illegal_op;
    uninit_ev = ex_ok && exec_i.uninit_w_ptr;
    math_ev = ex_ok && (exec_i.div_zero
      || (s_r.ctrl[rtu_pkg::CTRL_OVA_EN] && exec_i.ovf_a31 && !exec_i.guard_used)
      || (s_r.ctrl[rtu_pkg::CTRL_OVB_EN] && exec_i.ovf_b31 && !exec_i.guard_used)
      || (s_r.ctrl[rtu_pkg::CTRL_COV_EN] && (exec_i.ovf_a39 || exec_i.ovf_b39) && exec_i.sat_off)
      || (exec_i.is_shift && exec_i.shift_amt > rtu_pkg::MAX_SHIFT));
    misaligned = addr_i.data_acc && addr_i.word_acc && addr_i.data_addr[0];
    unimpl_data = addr_i.data_acc && (addr_i.dual_space
      ? (addr_i.y_access ? !addr_i.y_in_range : !addr_i.x_in_range)
      : addr_i.data_unimpl);
    addr_ev = misaligned || unimpl_data || addr_i.prog_data_unimpl || addr_i.fetch_vector
      || (addr_i.pc_load && addr_i.pc_unimpl) || addr_i.vector_invalid;
    stack_ev = addr_i.sp_load && (addr_i.sp_value > s_r.stack_limit
      || addr_i.sp_value < rtu_pkg::STACK_FLOOR);
    osc_ev = osc_s;
    new_traps = {osc_ev, stack_ev, addr_ev, math_ev};
    multi_trap = (new_traps & (new_traps - 4'h1)) != 4'h0;
    if (osc_ev)
      top_prio = rtu_pkg::PRIO_OSC;
    else if (stack_ev)
      top_prio = rtu_pkg::PRIO_STACK;
    else if (addr_ev)
      top_prio = rtu_pkg::PRIO_ADDR;
    else
      top_prio = rtu_pkg::PRIO_MATH;
    // equal or lower hard trap while hard pending
    hard_conflict = s_r.hard_active && (new_traps != 4'h0)
      && top_prio >= rtu_pkg::PRIO_HARD_MIN && top_prio <= s_r.cur_trap_prio;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  // Internal resets reuse the power-up path

  logic rst_src;
  logic wb_hit;
  logic [ADDR_W-1:0] offs;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pc_load = 1'b0;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    offs = wb_adr_i[ADDR_W-1:0];
    rst_src = ext_s || por_s || bor_s || wdt_s || illegal_ev || uninit_ev
      || multi_trap || hard_conflict;
    unique case (s_r.state)
      rtu_pkg::RTU_RUN:
      begin
        if (new_traps != 4'h0 && !multi_trap)
        begin
          s_nxt.state = rtu_pkg::RTU_TRAP;
          s_nxt.trap_req = 1'b1;
          s_nxt.trap_prio = top_prio;
          s_nxt.cur_trap_prio = top_prio;
          s_nxt.hard_active = top_prio >= rtu_pkg::PRIO_HARD_MIN;
          s_nxt.trap_pend = s_r.trap_pend | new_traps;
          s_nxt.cpu_priority_level = top_prio;
        end
      end
      rtu_pkg::RTU_TRAP:
      begin
        s_nxt.trap_req = 1'b0;
        s_nxt.trap_pend = s_r.trap_pend | new_traps;
        if (trap_return_i)
        begin
          s_nxt.state = rtu_pkg::RTU_RUN;
          s_nxt.hard_active = 1'b0;
          s_nxt.cur_trap_prio = 4'h0;
          s_nxt.cpu_priority_level = rtu_pkg::PRIO_ALL_OFF & 4'h0;
        end
      end
      rtu_pkg::RTU_RESET:
      begin
        s_nxt.core_reset = 1'b0;
        s_nxt.pc = rtu_pkg::RESET_VECTOR;
        s_nxt.pc_load = 1'b1;
        s_nxt.state = rtu_pkg::RTU_FETCH_JUMP;
      end
      rtu_pkg::RTU_FETCH_JUMP:
      begin
        if (jump_valid_i)
        begin
          s_nxt.pc = jump_target_i;
          s_nxt.pc_load = 1'b1;
          s_nxt.state = rtu_pkg::RTU_RUN;
        end
      end
    endcase
    // One registered ack or err per request
    wb_hit = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
    if (wb_hit)
    begin
      unique case (offs)
        ADDR_W'(rtu_pkg::ADR_CTRL):
        begin
          s_nxt.ack = 1'b1;
          if (wb_we_i && wb_sel_i[0])
          begin
            s_nxt.ctrl = {1'b0, wb_dat_i[2:0]};
            if (wb_dat_i[rtu_pkg::CTRL_ACK])
              s_nxt.trap_pend = 4'h0;
          end
          s_nxt.dat = {28'h0000000, s_r.ctrl};
        end
        ADDR_W'(rtu_pkg::ADR_STATUS):
        begin
          s_nxt.ack = 1'b1;
          if (wb_we_i && wb_sel_i[0])
            s_nxt.trap_pend = s_r.trap_pend & ~wb_dat_i[3:0];
          s_nxt.dat = {28'h0000000, s_r.trap_pend};
        end
        ADDR_W'(rtu_pkg::ADR_STACK_LIMIT):
        begin
          s_nxt.ack = 1'b1;
          if (wb_we_i && wb_sel_i[0])
            s_nxt.stack_limit[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1])
            s_nxt.stack_limit[15:8] = wb_dat_i[15:8];
          s_nxt.dat = {16'h0000, s_r.stack_limit};
        end
        ADDR_W'(rtu_pkg::ADR_RESET_CTRL):
        begin
          s_nxt.ack = 1'b1;
          if (wb_we_i && wb_sel_i[0])
            s_nxt.reset_ctrl[7:0] = s_r.reset_ctrl[7:0] & ~wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1])
            s_nxt.reset_ctrl[15:8] = s_r.reset_ctrl[15:8] & ~wb_dat_i[15:8];
          s_nxt.dat = {16'h0000, s_r.reset_ctrl};
        end
        ADDR_W'(rtu_pkg::ADR_PRIO):
        begin
          s_nxt.ack = 1'b1;
          // level written outside traps
          // Trap entry in this cycle keeps its level
          if (wb_we_i && wb_sel_i[0] && s_r.state != rtu_pkg::RTU_TRAP && s_nxt.state != rtu_pkg::RTU_TRAP)
            s_nxt.cpu_priority_level = {1'b0, wb_dat_i[2:0]};
          s_nxt.dat = {28'h0000000, s_r.cpu_priority_level};
        end
        default:
        begin
          s_nxt.err = 1'b1;
          s_nxt.dat = 32'h00000000;
        end
      endcase
    end
    // Set wins: a trap event beats a same-cycle clear
    if (s_r.state == rtu_pkg::RTU_RUN || s_r.state == rtu_pkg::RTU_TRAP)
      s_nxt.trap_pend = s_nxt.trap_pend | new_traps;
    if (rst_src)
    begin
      s_nxt.state = rtu_pkg::RTU_RESET;
      s_nxt.core_reset = 1'b1;
      s_nxt.trap_req = 1'b0;
      s_nxt.trap_pend = 4'h0;
      s_nxt.hard_active = 1'b0;
      s_nxt.cur_trap_prio = 4'h0;
      s_nxt.cpu_priority_level = 4'h0;
      s_nxt.pc = rtu_pkg::RESET_VECTOR;
      s_nxt.ctrl = rtu_pkg::CTRL_RST;
      if (hard_conflict)
        s_nxt.reset_ctrl[rtu_pkg::RC_TRAP_CONFLICT] = 1'b1;
      if (illegal_ev)
        s_nxt.reset_ctrl[rtu_pkg::RC_ILLEGAL] = 1'b1;
      if (uninit_ev)
        s_nxt.reset_ctrl[rtu_pkg::RC_UNINIT_W] = 1'b1;
      if (wdt_s)
        s_nxt.reset_ctrl[rtu_pkg::RC_WATCHDOG] = 1'b1;
      if (bor_s)
        s_nxt.reset_ctrl[rtu_pkg::RC_BROWNOUT] = 1'b1;
      if (por_s)
        s_nxt.reset_ctrl[rtu_pkg::RC_POWERON] = 1'b1;
      if (ext_s)
        s_nxt.reset_ctrl[rtu_pkg::RC_EXTERNAL] = 1'b1;
      if (multi_trap)
        s_nxt.reset_ctrl[rtu_pkg::RC_LOCKOUT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // Reset branch loads constants only

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.state <= rtu_pkg::RTU_RESET;
      s_r.core_reset <= 1'b1;
      s_r.stack_limit <= rtu_pkg::STACK_LIMIT_RST;
      s_r.reset_ctrl <= rtu_pkg::RESET_CTRL_RST;
      s_r.pc <= rtu_pkg::RESET_VECTOR;
    end
    else
      s_r <= s_nxt;
  end

  // Irq enable is a registered compare; trap_top bit follows the level
  logic irq_en_r;
  logic abort_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_en_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      irq_en_r <= s_nxt.cpu_priority_level < rtu_pkg::PRIO_ALL_OFF;
      abort_r <= ex_ok && exec_i.div_zero;
    end
  end

  // All outputs come straight from registers
  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign wb_err_o = s_r.err;
  assign core_reset_o = s_r.core_reset;
  assign pc_o = s_r.pc;
  assign pc_load_o = s_r.pc_load;
  assign trap_req_o = s_r.trap_req;
  assign trap_prio_o = s_r.trap_prio;
  assign cpu_priority_level_o = s_r.cpu_priority_level;
  assign irq_enable_o = irq_en_r;
  assign abort_op_o = abort_r;

endmodule

// File: tb/rtu_sva.sv
// Port checker for the reset and trap unit.
// Assumes one clock domain; bound to every rtu_reset_trap.
module rtu_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rtu_pkg::rtu_exec_type exec_i,
  input wire rtu_pkg::rtu_addr_type addr_i,
  input wire logic core_reset_o,
  input wire logic [23:0] pc_o,
  input wire logic pc_load_o,
  input wire logic trap_req_o,
  input wire logic [3:0] trap_prio_o,
  input wire logic [3:0] cpu_priority_level_o,
  input wire logic irq_enable_o,
  input wire logic abort_op_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic run;
  // Single events only count in normal running
  assign run = !core_reset_o && !cpu_priority_level_o[3];
  ////////////////////////////////////////
  AST_RST_PC: assert property (disable iff (1'b0) rst_i |=> core_reset_o && pc_o == 24'h0)
    else $error("pc not held at zero in reset");
  AST_REL_VEC: assert property ($fell(rst_i) |-> ##[0:2] pc_load_o && pc_o == 24'h0)
    else $error("no fetch from zero after reset");
  AST_TRAP_TOP: assert property (trap_req_o |-> trap_prio_o[3] && cpu_priority_level_o[3])
    else $error("trap level below 8");
  AST_MASK7: assert property (cpu_priority_level_o == 4'h7 && $stable(cpu_priority_level_o) |-> !irq_enable_o)
    else $error("interrupts on at level 7");
  AST_DIV0: assert property (run && exec_i.valid && exec_i.div_zero && !addr_i.sp_load |=>
    abort_op_o && trap_req_o && trap_prio_o == rtu_pkg::PRIO_MATH)
    else $error("divide by zero not trapped");
  AST_SHIFT: assert property (run && exec_i.valid && exec_i.is_shift && exec_i.shift_amt > rtu_pkg::MAX_SHIFT
    |=> trap_req_o && trap_prio_o == rtu_pkg::PRIO_MATH)
    else $error("oversize shift not trapped");
  AST_FLUSH: assert property (run && exec_i.valid && exec_i.flushed |=> !core_reset_o [*4])
    else $error("flushed opcode caused reset");
  AST_ILLEGAL: assert property (run && exec_i.valid && exec_i.illegal_op && !exec_i.flushed
    |-> ##[1:4] core_reset_o)
    else $error("illegal opcode without reset");
  AST_UNDER: assert property (run && addr_i.sp_load && addr_i.sp_value < rtu_pkg::STACK_FLOOR
    && !exec_i.valid |=> trap_req_o && trap_prio_o == rtu_pkg::PRIO_STACK)
    else $error("stack underflow not trapped");
  AST_LOCK: assert property (run && exec_i.div_zero && exec_i.valid && addr_i.sp_load
    && addr_i.sp_value < rtu_pkg::STACK_FLOOR |-> ##[1:4] core_reset_o)
    else $error("simultaneous traps without reset");
  AST_CONFLICT: assert property (cpu_priority_level_o[3] && trap_prio_o == rtu_pkg::PRIO_STACK
    && addr_i.pc_load && addr_i.pc_unimpl |-> ##[1:4] core_reset_o)
    else $error("hard trap conflict without reset");
  COV_OSC: cover property (trap_req_o && trap_prio_o == rtu_pkg::PRIO_OSC);
  COV_ABORT: cover property (abort_op_o);
  COV_RESTART: cover property ($fell(core_reset_o));
endmodule

bind rtu_reset_trap rtu_sva u_sva (.clk_i, .rst_i, .exec_i, .addr_i, .core_reset_o, .pc_o, .pc_load_o,
  .trap_req_o, .trap_prio_o, .cpu_priority_level_o, .irq_enable_o, .abort_op_o);

// File: tb/rtu_core_model.sv
// Behavioural core pipeline beside the trap unit.
// Assumes the unit's clock; answers after a random delay.
module rtu_core_model (
  input wire logic clk_i,
  input wire logic core_reset_i,
  input wire logic [23:0] pc_i,
  input wire logic pc_load_i,
  input wire logic trap_req_i,
  output logic [23:0] jump_target_o,
  output logic jump_valid_o,
  output logic trap_return_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int jd = -1;
  int rd = -1;
  initial
  begin
    jump_target_o = '0;
    jump_valid_o = 1'b0;
    trap_return_o = 1'b0;
  end
  ////////////////////////////////////////
  // jump word after fetch
  always @(posedge clk_i)
  begin
    jump_valid_o <= jd == 0;
    // Target only meaningful with valid
    jump_target_o <= jd == 0 ? {7'h0, 16'($urandom), 1'b0} : ~jump_target_o;
    trap_return_o <= rd == 0;
    jd <= pc_load_i && pc_i == 24'h0 ? int'($urandom_range(0, 3)) : core_reset_i ? -1 : jd - int'(jd >= 0);
    rd <= core_reset_i ? -1 : trap_req_i ? int'($urandom_range(4, 7)) : rd - int'(rd >= 0);
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the reset and trap unit.
// Assumes the core model answers reset jumps and trap returns.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] pins = '0;
  rtu_pkg::rtu_exec_type ex = '0;
  rtu_pkg::rtu_addr_type ad = '0;
  logic [31:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, core_reset_o, pc_load_o, trap_req_o, jump_valid_i, trap_return_i;
  logic irq_enable_o, abort_op_o;
  logic [23:0] pc_o, jump_target_i;
  logic [3:0] trap_prio_o, cpu_priority_level_o;
  logic [31:0] rq[$];
  logic [3:0] tq[$];
  logic [23:0] pq[$];
  logic [3:0] tx;
  int errors = 0;
  int num_checks = 0;
  int cnt[2] = '{0, 0};
  byte pr[23] = '{11, 11, 0, 11, 0, 11, 12, 12, 12, 12, 13, 0, 13, 14, 0, 0, 0, 0, 13, 0, 0, 0, 0};
  logic [15:0] rc[9] = '{16'h0, 16'h4000, 16'h0200, 16'h0100, 16'h8000, 16'h2, 16'h10, 16'h80, 16'h1};

  always #10 clk_i = ~clk_i;

  rtu_reset_trap u_dut (.clk_i, .rst_i, .ext_reset_i(pins[1]), .poweron_reset_i(pins[2]),
    .brownout_reset_i(pins[4]), .watchdog_timeout_i(pins[0]), .osc_fail_i(pins[3]), .exec_i(ex),
    .addr_i(ad), .jump_target_i, .jump_valid_i, .trap_return_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .core_reset_o, .pc_o,
    .pc_load_o, .trap_req_o, .trap_prio_o, .cpu_priority_level_o, .irq_enable_o, .abort_op_o);

  rtu_core_model u_core (.clk_i, .core_reset_i(core_reset_o), .pc_i(pc_o), .pc_load_i(pc_load_o),
    .trap_req_i(trap_req_o), .jump_target_o(jump_target_i), .jump_valid_o(jump_valid_i),
    .trap_return_o(trap_return_i));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wt(input int i, input int o);
    int n;
    n = 0;
    while (cnt[i] == o && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (cnt[i] == o)
    begin
      errors++;
      end_of_test;
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= 32'(a);
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!wb_ack_o && !wb_err_o && n < 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(32'(wb_err_o), 32'(a == 8'h20));
    if (!wb_ack_o && !wb_err_o)
    begin
      errors++;
      end_of_test;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, '0, 4'hF);
  endtask

  task automatic ev(input int k);
    rtu_pkg::rtu_exec_type e;
    rtu_pkg::rtu_addr_type a;
    logic [4:0] p;
    e = '0;
    a = '0;
    p = '0;
    case (k)
      0: e.div_zero = 1'b1;
      1: {e.is_shift, e.shift_amt} = {1'b1, rtu_pkg::MAX_SHIFT + 5'h1};
      2: {e.is_shift, e.shift_amt} = {1'b1, rtu_pkg::MAX_SHIFT};
      3: e.ovf_a31 = 1'b1;
      4: {e.ovf_a31, e.guard_used} = 2'h3;
      5: {e.ovf_b39, e.sat_off} = 2'h3;
      6: {a.data_acc, a.word_acc, a.data_addr} = {2'h3, 16'($urandom) | 16'h1};
      7: {a.pc_load, a.pc_unimpl} = 2'h3;
      8: a.vector_invalid = 1'b1;
      9: a.fetch_vector = 1'b1;
      10, 17, 18: {a.sp_load, a.sp_value} = {1'b1, rtu_pkg::STACK_FLOOR - 16'h2};
      11: {a.sp_load, a.sp_value} = {1'b1, rtu_pkg::STACK_FLOOR};
      12: {a.sp_load, a.sp_value} = {1'b1, 16'h1002 + 16'($urandom_range(0, 999) * 2)};
      14: {e.flushed, e.illegal_op} = 2'h3;
      15: e.illegal_op = 1'b1;
      16: e.uninit_w_ptr = 1'b1;
      default: p = 5'h1 << (k % 5);
    endcase
    if (k == 17)
      e.div_zero = 1'b1;
    e.valid = |e;
    @(posedge clk_i);
    ex <= e;
    ad <= a;
    pins <= p;
    @(posedge clk_i);
    ex <= '0;
    ad <= '0;
    pins <= '0;
  endtask
  ////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (wb_ack_o && !wb_we_i)
      chk(wb_dat_o, rq.size() ? rq.pop_front() : 'x);
    if (trap_req_o)
    begin
      tx = tq.size() ? tq.pop_front() : 4'hX;
      chk(32'(trap_prio_o), 32'(tx));
      chk(32'(cpu_priority_level_o), 32'(tx));
    end
    if (jump_valid_i)
      pq.push_back(jump_target_i);
    if (pc_load_o && pq.size())
    begin
      chk(32'(pc_o), 32'(pq.pop_front()));
      cnt[0]++;
    end
    if (trap_return_i)
      cnt[1]++;
  end

  initial
  begin
    void'($urandom(32'hD6A69FB6));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(0, 0);
    rd(rtu_pkg::ADR_RESET_CTRL, 32'(rtu_pkg::RESET_CTRL_RST));
    rd(rtu_pkg::ADR_STACK_LIMIT, 32'(rtu_pkg::STACK_LIMIT_RST));
    bus(rtu_pkg::ADR_RESET_CTRL, 1'b1, 32'hFFFF, 4'hF);
    bus(rtu_pkg::ADR_STACK_LIMIT, 1'b1, 32'h1000, 4'h3);
    bus(rtu_pkg::ADR_CTRL, 1'b1, 32'h7, 4'h1);
    bus(rtu_pkg::ADR_PRIO, 1'b1, 32'(rtu_pkg::PRIO_ALL_OFF), 4'h1);
    bus(8'h20, 1'b0, '0, 4'hF);
    rd(rtu_pkg::ADR_PRIO, 32'(rtu_pkg::PRIO_ALL_OFF));
    rd(rtu_pkg::ADR_STACK_LIMIT, 32'h1000);
    chk(32'(irq_enable_o), 32'h0);
    // Traps first, from level 7 until the first trap returns to level 0, resets last
    for (int k = 0; k < 23; k++)
    begin
      int r, j;
      r = cnt[1];
      j = cnt[0];
      if (pr[k] != 0)
        tq.push_back(4'(pr[k]));
      ev(k);
      if (k < 2)
      begin
        @(posedge clk_i);
        chk(32'(abort_op_o), 32'(k == 0));
      end
      if (k == 18)
        ev(7);
      if (k > 14)
        wt(0, j);
      else if (pr[k] != 0)
        wt(1, r);
      else
        repeat (10) @(posedge clk_i);
      if (k == 13)
        rd(rtu_pkg::ADR_STATUS, 32'hF);
      if (k > 13)
      begin
        rd(rtu_pkg::ADR_RESET_CTRL, 32'(rc[k - 14]));
        bus(rtu_pkg::ADR_RESET_CTRL, 1'b1, 32'hFFFF, 4'hF);
      end
      repeat (2) @(posedge clk_i);
    end
    end_of_test;
  end
endmodule
